//--- dv/tpcg_clock_gen_asserts.sv
// checker for the phase clock generator ports
`timescale 1ns/10ps
module tpcg_clock_gen_asserts (
  input wire core_clk, input wire reset,
  input wire divide_seven_select, input wire divide_five_select,
  input wire phase_two_wide_select, input wire phase_one_n_reg,
  input wire phase_two_n_reg, input wire video_dot_toggle_reg,
  input wire cycle_start_reg, input wire [2:0] divide_ratio_reg
);
  wire s7 = divide_seven_select;
  wire f5 = divide_five_select & !s7;
  wire wd = phase_two_wide_select;
  wire p1 = phase_one_n_reg;
  wire p2 = phase_two_n_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  no_overlap_a: assert property (p1 || p2) else $error("overlap");
  ph1_wide_a: assert property (s7 && $fell(p1) |=> !p1 ##1 p1) else $error("ph1");
  seven_period_a: assert property (s7 && $fell(p1) |-> ##7 $fell(p1)) else $error("p7");
  five_period_a: assert property (f5 && $fell(p1) |-> ##5 $fell(p1)) else $error("p5");
  ph2_wide_a: assert property (wd && s7 && $rose(p1) |-> !p2[*4] ##1 p2)
    else $error("ph2 w");
  ph2_five_a: assert property (wd && f5 && $rose(p1) |-> !p2[*3] ##1 p2)
    else $error("ph2 f");
  ph2_narrow_a: assert property (!wd && !s7 && !f5 && $rose(p1) |-> !p2[*3] ##1 p2)
    else $error("ph2 n");
  ratio_code_a: assert property (!$past(reset) && !$past(reset, 2) |->
    divide_ratio_reg == (s7 ? 3'h7 : f5 ? 3'h5 : 3'h6)) else $error("ratio");
  dot_toggle_a: assert property (!$past(reset) && !$past(reset, 2) |->
    video_dot_toggle_reg != $past(video_dot_toggle_reg)) else $error("toggle");
  cycle_start_a: assert property (!f5 && $rose(p1) |->
    ##2 cycle_start_reg ##1 !cycle_start_reg) else $error("start");
  five_start_a: assert property (f5 && $rose(p1) |->
    ##1 cycle_start_reg ##1 !cycle_start_reg) else $error("start f");
endmodule // tpcg_clock_gen_asserts
bind tpcg_clock_gen tpcg_clock_gen_asserts chk (
  .core_clk(core_clk), .reset(reset),
  .divide_seven_select(divide_seven_select), .divide_five_select(divide_five_select),
  .phase_two_wide_select(phase_two_wide_select), .phase_one_n_reg(phase_one_n_reg),
  .phase_two_n_reg(phase_two_n_reg), .video_dot_toggle_reg(video_dot_toggle_reg),
  .cycle_start_reg(cycle_start_reg), .divide_ratio_reg(divide_ratio_reg)
);

//--- dv/tpcg_clock_gen_tb.sv
// testbench for the phase clock generator
`timescale 1ns/10ps
module tpcg_clock_gen_tb;
  logic core_clk = 1'h0, reset = 1'h1, divide_seven_select = 1'h0, divide_five_select = 1'h0;
  logic phase_two_wide_select = 1'h0, phase_one_n_reg, phase_two_n_reg;
  logic video_dot_toggle_reg, cycle_start_reg;
  logic [2:0] divide_ratio_reg;
  logic [3:0] per, w1, w2;
  int n_fail = 0, samples_checked = 0;
  tpcg_clock_gen uut (
    .core_clk(core_clk), .reset(reset),
    .divide_seven_select(divide_seven_select), .divide_five_select(divide_five_select),
    .phase_two_wide_select(phase_two_wide_select), .phase_one_n_reg(phase_one_n_reg),
    .phase_two_n_reg(phase_two_n_reg), .video_dot_toggle_reg(video_dot_toggle_reg),
    .cycle_start_reg(cycle_start_reg), .divide_ratio_reg(divide_ratio_reg)
  );
  tpcg_cpu_model cpu (.clk(core_clk), .p1_n(phase_one_n_reg), .p2_n(phase_two_n_reg),
    .per(per), .w1(w1), .w2(w2));
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic run(input logic s7, f5, wd, input logic [3:0] ep, e1, e2, e3);
    logic [3:0] hit;
    logic [3:0] flips;
    logic dot;
    @(negedge core_clk);
    reset = 1'h1;
    divide_seven_select = s7;
    divide_five_select = f5;
    phase_two_wide_select = wd;
    repeat (20) @(negedge core_clk);
    reset = 1'h0;
    repeat (40) @(negedge core_clk);
    chk("per", ep, per);
    chk("w1", e1, w1);
    chk("w2", e2, w2);
    chk("ratio", e3, {1'h0, divide_ratio_reg});
    hit = 4'h0;
    flips = 4'h0;
    dot = video_dot_toggle_reg;
    repeat (ep) begin
      @(negedge core_clk);
      if (cycle_start_reg === 1'h1) hit++;
      if (video_dot_toggle_reg !== dot) flips++;
      dot = video_dot_toggle_reg;
    end
    chk("start", 4'h1, hit);
    chk("dot", ep, flips);
    $display("done %b%b%b", s7, f5, wd);
  endtask
  task stop_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #10000;
    n_fail++;
    stop_test;
  end
  initial begin
    run(1'h1, 1'h0, 1'h1, 4'h7, 4'h2, 4'h4, 4'h7);
    run(1'h0, 1'h0, 1'h0, 4'h6, 4'h1, 4'h3, 4'h6);
    run(1'h0, 1'h1, 1'h1, 4'h5, 4'h1, 4'h3, 4'h5);
    run(1'h1, 1'h1, 1'h1, 4'h7, 4'h2, 4'h4, 4'h7);
    stop_test;
  end
endmodule // tpcg_clock_gen_tb

//--- dv/tpcg_cpu_model.sv
// processor clock inputs: measure phase widths and period
`timescale 1ns/10ps
module tpcg_cpu_model (
  input wire clk, input wire p1_n, input wire p2_n,
  output logic [3:0] per, output logic [3:0] w1, output logic [3:0] w2
);
  logic [3:0] a = 4'h0, b = 4'h0, c = 4'h0;
  logic q = 1'h1;
  always @(posedge clk) begin
    q <= p1_n;
    c <= (q & !p1_n) ? 4'h1 : c + 4'h1;
    if (q & !p1_n) per <= c;
    a <= p1_n ? 4'h0 : a + 4'h1;
    if (p1_n && a != 0) w1 <= a;
    b <= p2_n ? 4'h0 : b + 4'h1;
    if (p2_n && b != 0) w2 <= b;
  end
endmodule // tpcg_cpu_model

//--- src/tpcg_clock_gen.v
// two-phase processor clock generator driven by the fundamental dot clock
`timescale 1ns/10ps

`include "tpcg_regs.vh"

module tpcg_clock_gen (
  // fundamental clock and power-up reset
  input wire core_clk,
  input wire reset,
  // static strap selections
  input wire divide_seven_select,
  input wire divide_five_select,
  input wire phase_two_wide_select,
  // processor phase clocks, active low
  output reg phase_one_n_reg,
  output reg phase_two_n_reg,
  // forwarded fundamental clock marker for the video generator
  output reg video_dot_toggle_reg,
  // status
  output reg cycle_start_reg,
  output reg [`TPCG_RATIO_W-1:0] divide_ratio_reg
);

  // counter state
  reg [`TPCG_STAGES-1:0] ring_reg;
  reg [`TPCG_STAGES-1:0] ring_next;
  reg feedback_in;

  // phase decodes of the next counter state
  reg phase_one_low;
  reg phase_two_low;
  reg phase_one_n_next;
  reg phase_two_n_next;

  // status next values
  reg video_dot_toggle_next;
  reg cycle_start_next;
  reg [`TPCG_RATIO_W-1:0] divide_ratio_next;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // nand feedback with its second input chosen by the straps
  function nand_feedback;
    input [`TPCG_STAGES-1:0] ring;
    input sel_seven;
    input sel_five;
    reg second_in;
    begin
      if (sel_seven) begin
        second_in = ring[`TPCG_STAGE_D];
      end else if (sel_five) begin
        second_in = ring[`TPCG_STAGE_B];
      end else begin
        // no option fitted: the spare input sits high
        second_in = `TPCG_NAND_PULLUP;
      end
      nand_feedback = ~(ring[`TPCG_STAGE_C] & second_in);
    end
  endfunction

  // phase one low window
  function phase_one_decode;
    input [`TPCG_STAGES-1:0] ring;
    begin
      phase_one_decode = ring[`TPCG_STAGE_B] & ring[`TPCG_STAGE_D];
    end
  endfunction

  // phase two low window, wide or narrow
  function phase_two_decode;
    input [`TPCG_STAGES-1:0] ring;
    input wide;
    begin
      if (wide) begin
        phase_two_decode = ~ring[`TPCG_STAGE_B] | ~ring[`TPCG_STAGE_C];
      end else begin
        phase_two_decode = ~ring[`TPCG_STAGE_B];
      end
    end
  endfunction

  // first state of a counting cycle: stage one set, stage two clear
  // the divide-by-five loop never passes through 1000, hence two stages only
  function cycle_start_decode;
    input [`TPCG_STAGES-1:0] ring;
    begin
      cycle_start_decode = ring[`TPCG_STAGE_A] & ~ring[`TPCG_STAGE_B];
    end
  endfunction

  // ratio code for the status port; seven wins when both straps are set
  function [`TPCG_RATIO_W-1:0] ratio_decode;
    input sel_seven;
    input sel_five;
    begin
      if (sel_seven) begin
        ratio_decode = `TPCG_RATIO_SEVEN;
      end else if (sel_five) begin
        ratio_decode = `TPCG_RATIO_FIVE;
      end else begin
        ratio_decode = `TPCG_RATIO_SIX;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ring counter

  always @* begin
    feedback_in = nand_feedback(ring_reg, divide_seven_select, divide_five_select);
    ring_next = {feedback_in, ring_reg[`TPCG_STAGE_A:`TPCG_STAGE_C]};
  end

  // straps are read every cycle, so they must sit still once reset is let go
  // single fundamental clock
  always @(posedge core_clk) begin
    if (reset) begin
      ring_reg <= `TPCG_RING_RESET;
    end else begin
      ring_reg <= ring_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase decode
  // decoding the next counter state lets each phase flop change on the same
  // edge as the counter while the outputs still come straight from flops

  always @* begin
    phase_one_low = phase_one_decode(ring_next);
    phase_two_low = phase_two_decode(ring_next, phase_two_wide_select);
    phase_one_n_next = ~phase_one_low;
    phase_two_n_next = ~(phase_two_low & ~phase_one_low);
  end

  always @(posedge core_clk) begin
    if (reset) begin
      phase_one_n_reg <= `TPCG_PHASE_IDLE;
    end else begin
      phase_one_n_reg <= phase_one_n_next;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      phase_two_n_reg <= `TPCG_PHASE_IDLE;
    end else begin
      phase_two_n_reg <= phase_two_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // video forward
  // a toggling flop stands in for the forwarded clock, one transition a dot

  always @* begin
    video_dot_toggle_next = ~video_dot_toggle_reg;
  end

  always @(posedge core_clk) begin
    if (reset) begin
      video_dot_toggle_reg <= `TPCG_DOT_RESET;
    end else begin
      video_dot_toggle_reg <= video_dot_toggle_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status

  always @* begin
    cycle_start_next = cycle_start_decode(ring_next);
  end

  always @* begin
    divide_ratio_next = ratio_decode(divide_seven_select, divide_five_select);
  end

  always @(posedge core_clk) begin
    if (reset) begin
      cycle_start_reg <= `TPCG_START_RESET;
    end else begin
      cycle_start_reg <= cycle_start_next;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      divide_ratio_reg <= `TPCG_RATIO_SIX;
    end else begin
      divide_ratio_reg <= divide_ratio_next;
    end
  end

endmodule // tpcg_clock_gen

//--- src/tpcg_regs.vh
// constants for the two-phase processor clock generator
`ifndef TPCG_REGS_VH
`define TPCG_REGS_VH

// nominal fundamental clock figures
`define TPCG_FUND_FREQ_HZ 14318180
`define TPCG_FUND_PERIOD_NS 70

// ring counter shape
`define TPCG_STAGES 4
`define TPCG_RING_RESET 4'h0
`define TPCG_STAGE_A 3
`define TPCG_STAGE_B 2
`define TPCG_STAGE_C 1
`define TPCG_STAGE_D 0

// divide ratio codes shown on the status port
`define TPCG_RATIO_W 3
`define TPCG_RATIO_FIVE 3'h5
`define TPCG_RATIO_SIX 3'h6
`define TPCG_RATIO_SEVEN 3'h7

// first state of the six and seven counting cycles (stage a alone set)
`define TPCG_CYCLE_START 4'h8

// nominal phase pulse widths in ns
`define TPCG_PH1_WIDE_NS 140
`define TPCG_PH1_NARROW_NS 70
`define TPCG_PH2_WIDE_NS 280
`define TPCG_PH2_NARROW_NS 210

// idle and reset levels of the output flops
`define TPCG_PHASE_IDLE 1'h1
`define TPCG_DOT_RESET 1'h0
`define TPCG_START_RESET 1'h0

// spare nand input level when no feedback option is fitted
`define TPCG_NAND_PULLUP 1'h1

`endif
